/* design/dim_period_gen.sv */
// dimming period generator: (code+1) steps of 1.5 us, capped on-time
// assumes 40 MHz clk; step rate is a one-cycle enable from a divider
`timescale 1ns/1ps
`default_nettype none
module dim_period_gen
    import led_cfg_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // link to bank
    pwm_link_if.gen   link
);

    localparam logic [6:0] STEP_LAST = 7'(STEP_CYCLES - 1);

    logic [6:0]          div_q;
    logic                step_tick;
    logic [PERIOD_W-1:0] step_q;
    logic [PERIOD_W-1:0] on_eff;

    assign step_tick = (div_q == STEP_LAST);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
        end else if (!link.run || step_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    // period counter wraps after code+1 steps
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            step_q <= '0;
        end else if (!link.run) begin
            step_q <= '0;
        end else if (step_tick) begin
            step_q <= (step_q >= link.period_code) ? '0 : step_q + 13'h0001;
        end
    end

    // on-time request cannot exceed its own limit
    assign on_eff = (link.on_steps > ON_TIME_LIMIT) ? ON_TIME_LIMIT : link.on_steps;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.pwm_on         <= 1'b0;
            link.period_start   <= 1'b0;
            link.full_duty_lost <= 1'b0;
        end else begin
            link.pwm_on         <= link.run && (step_q <= on_eff) && (link.on_steps != '0);
            link.period_start   <= link.run && step_tick && (step_q >= link.period_code);
            link.full_duty_lost <= (link.period_code > ON_TIME_LIMIT);
        end
    end

endmodule
`default_nettype wire

/* design/led_cfg_pkg.sv */
// constants, register map and types for the led driver configuration bank
// assumes a single 40 MHz clock shared by every user of the package
package led_cfg_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 10;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CHAN_ON_UPPER = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_ON_LOWER = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_UPPER  = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_LOWER  = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_OV_TRIP       = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DITHER_DERATE = 8'h05;

    // writable field masks, everything else reads zero
    localparam logic [DATA_W-1:0] MASK_CHAN_ON_UPPER = 8'h03;
    localparam logic [DATA_W-1:0] MASK_CHAN_ON_LOWER = 8'hff;
    localparam logic [DATA_W-1:0] MASK_PERIOD_UPPER  = 8'h1f;
    localparam logic [DATA_W-1:0] MASK_PERIOD_LOWER  = 8'hff;
    localparam logic [DATA_W-1:0] MASK_OV_TRIP       = 8'h1f;
    localparam logic [DATA_W-1:0] MASK_DITHER_DERATE = 8'h07;

    // reset values
    localparam logic [DATA_W-1:0] RST_CHAN_ON_UPPER = 8'h03;
    localparam logic [DATA_W-1:0] RST_CHAN_ON_LOWER = 8'hff;
    localparam logic [DATA_W-1:0] RST_PERIOD_UPPER  = 8'h0f;
    localparam logic [DATA_W-1:0] RST_PERIOD_LOWER  = 8'hff;
    localparam logic [DATA_W-1:0] RST_OV_TRIP       = 8'h1c;
    localparam logic [DATA_W-1:0] RST_DITHER_DERATE = 8'h00;

    // field positions
    localparam int BIT_DERATE    = 2;
    localparam int DITHER_HI_BIT = 1;
    localparam int DITHER_LO_BIT = 0;
    localparam int CH_UPPER_LSB  = 8;
    localparam int PERIOD_W      = 13;
    localparam int OV_CODE_W     = 5;

    // trip level: base volts plus one volt per code step
    localparam logic [5:0] OV_BASE_VOLTS = 6'h08;

    // dimming step timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_TIME_NS  = 1500;
    localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [PERIOD_W-1:0] ON_TIME_LIMIT = 13'h1998;

    typedef enum logic [1:0] {
        DITHER_NONE,
        DITHER_5PCT,
        DITHER_10PCT,
        DITHER_15PCT
    } dither_t;

endpackage

/* design/led_cfg_regs.sv */
// configuration register bank of a ten-channel led driver
// assumes a register port from the serial front end on the same clock;
// population straps and the external sync detect come from pins
`timescale 1ns/1ps
`default_nettype none
module led_cfg_regs
    import led_cfg_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // register port
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    output logic      [DATA_W-1:0]    reg_rdata,
    output logic                      reg_rvalid,
    // pins
    input  wire logic [NUM_CH-1:0]    unpopulated_pin,
    input  wire logic                 freq_set_or_ext_sync_pin,
    // startup sequencer
    input  wire logic                 start_req,
    output logic                      startup_running,
    output logic                      startup_halted,
    output logic                      fault_flag_n,
    // channel drive
    input  wire logic [PERIOD_W-1:0]  on_steps,
    output logic      [NUM_CH-1:0]    chan_drive,
    output logic                      period_start,
    output logic                      full_duty_lost,
    // boost and protection
    output logic      [OV_CODE_W-1:0] overvoltage_trip_code,
    output logic      [5:0]           ov_trip_volts,
    output logic                      thermal_derate_on,
    output dither_t                   dither_sel
);

    ////////////////////////////////////////////////////////////////////
    // storage

    logic [DATA_W-1:0] chan_on_upper_bits_q;
    logic [DATA_W-1:0] chan_on_lower_bits_q;
    logic [DATA_W-1:0] period_upper_q;
    logic [DATA_W-1:0] period_lower_q;
    logic [DATA_W-1:0] ov_trip_q;
    logic [DATA_W-1:0] dither_derate_q;

    logic [NUM_CH-1:0] chan_on;
    logic [NUM_CH-1:0] unpop_meta_q;
    logic [NUM_CH-1:0] unpop_q;
    logic              sync_meta_q;
    logic              ext_sync_q;
    logic              dither_level_hi;
    logic              dither_level_lo;

    function automatic logic hit(input logic [ADDR_W-1:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    // masked write keeps unused bits at zero
    function automatic logic [DATA_W-1:0] wr_field(input logic [DATA_W-1:0] m);
        return reg_wdata & m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // writes

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_on_upper_bits_q <= RST_CHAN_ON_UPPER;
            chan_on_lower_bits_q <= RST_CHAN_ON_LOWER;
        end else begin
            if (hit(ADDR_CHAN_ON_UPPER)) begin
                chan_on_upper_bits_q <= wr_field(MASK_CHAN_ON_UPPER);
            end
            if (hit(ADDR_CHAN_ON_LOWER)) begin
                chan_on_lower_bits_q <= wr_field(MASK_CHAN_ON_LOWER);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_upper_q <= RST_PERIOD_UPPER;
            period_lower_q <= RST_PERIOD_LOWER;
        end else begin
            if (hit(ADDR_PERIOD_UPPER)) begin
                period_upper_q <= wr_field(MASK_PERIOD_UPPER);
            end
            if (hit(ADDR_PERIOD_LOWER)) begin
                period_lower_q <= wr_field(MASK_PERIOD_LOWER);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ov_trip_q       <= RST_OV_TRIP;
            dither_derate_q <= RST_DITHER_DERATE;
        end else begin
            if (hit(ADDR_OV_TRIP)) begin
                ov_trip_q <= wr_field(MASK_OV_TRIP);
            end
            if (hit(ADDR_DITHER_DERATE)) begin
                dither_derate_q <= wr_field(MASK_DITHER_DERATE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reads, unmapped offsets return zero

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (!reg_rd) begin
                reg_rdata <= reg_rdata;
            end else if (reg_addr == ADDR_CHAN_ON_UPPER) begin
                reg_rdata <= chan_on_upper_bits_q;
            end else if (reg_addr == ADDR_CHAN_ON_LOWER) begin
                reg_rdata <= chan_on_lower_bits_q;
            end else if (reg_addr == ADDR_PERIOD_UPPER) begin
                reg_rdata <= period_upper_q;
            end else if (reg_addr == ADDR_PERIOD_LOWER) begin
                reg_rdata <= period_lower_q;
            end else if (reg_addr == ADDR_OV_TRIP) begin
                reg_rdata <= ov_trip_q;
            end else if (reg_addr == ADDR_DITHER_DERATE) begin
                reg_rdata <= dither_derate_q;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unpop_meta_q <= '0;
            unpop_q      <= '0;
            sync_meta_q  <= 1'b0;
            ext_sync_q   <= 1'b0;
        end else begin
            unpop_meta_q <= unpopulated_pin;
            unpop_q      <= unpop_meta_q;
            sync_meta_q  <= freq_set_or_ext_sync_pin;
            ext_sync_q   <= sync_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // startup check and channel drive

    assign chan_on = {chan_on_upper_bits_q[NUM_CH-CH_UPPER_LSB-1:0],
                      chan_on_lower_bits_q};

    startup_check u_startup (
        .clk          (clk),
        .reset_n      (reset_n),
        .start_req    (start_req),
        .running      (startup_running),
        .halted       (startup_halted),
        .chan_on      (chan_on),
        .unpopulated  (unpop_q),
        .fault_flag_n (fault_flag_n)
    );

    pwm_link_if link ();

    assign link.period_code = {period_upper_q[PERIOD_W-DATA_W-1:0], period_lower_q};
    assign link.on_steps    = on_steps;
    assign link.run         = startup_running;

    dim_period_gen u_pwm (
        .clk     (clk),
        .reset_n (reset_n),
        .link    (link)
    );

    // unpopulated channel never lit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_drive <= '0;
        end else begin
            chan_drive <= link.pwm_on ? (chan_on & ~unpop_q) : '0;
        end
    end

    assign period_start   = link.period_start;
    assign full_duty_lost = link.full_duty_lost;

    ////////////////////////////////////////////////////////////////////
    // boost and protection settings

    assign overvoltage_trip_code = ov_trip_q[OV_CODE_W-1:0];
    assign dither_level_hi       = dither_derate_q[DITHER_HI_BIT];
    assign dither_level_lo       = dither_derate_q[DITHER_LO_BIT];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ov_trip_volts     <= '0;
            thermal_derate_on <= 1'b0;
            dither_sel        <= DITHER_NONE;
        end else begin
            ov_trip_volts     <= OV_BASE_VOLTS + {1'b0, ov_trip_q[OV_CODE_W-1:0]};
            thermal_derate_on <= dither_derate_q[BIT_DERATE];
            dither_sel        <= ext_sync_q ? DITHER_NONE
                               : dither_t'({dither_level_hi, dither_level_lo});
        end
    end

endmodule
`default_nettype wire

/* design/pwm_link_if.sv */
// carrier between the register bank and the dimming period generator
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface pwm_link_if;
    import led_cfg_pkg::*;
    logic [PERIOD_W-1:0] period_code;
    logic [PERIOD_W-1:0] on_steps;
    logic                run;
    logic                period_start;
    logic                pwm_on;
    logic                full_duty_lost;

    modport bank (output period_code, output on_steps, output run,
                  input period_start, input pwm_on, input full_duty_lost);
    modport gen  (input period_code, input on_steps, input run,
                  output period_start, output pwm_on, output full_duty_lost);
endinterface
`default_nettype wire

/* design/startup_check.sv */
// startup check: enabled channel that is unpopulated blocks startup
// assumes population straps already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module startup_check
    import led_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // sequencer
    input  wire logic              start_req,
    output logic                   running,
    output logic                   halted,
    // channel state
    input  wire logic [NUM_CH-1:0] chan_on,
    input  wire logic [NUM_CH-1:0] unpopulated,
    output logic                   fault_flag_n
);

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} start_state_t;

    start_state_t state_q;
    logic         bad;

    assign bad = |(chan_on & unpopulated);

    // a bad combination refuses startup, new request retries
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE, ST_HALT: begin
                    if (start_req) begin
                        state_q <= bad ? ST_HALT : ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (bad) begin
                        state_q <= ST_HALT;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // low only for enabled and unpopulated
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_flag_n <= 1'b1;
        end else begin
            fault_flag_n <= !bad;
        end
    end

    assign running = (state_q == ST_RUN);
    assign halted  = (state_q == ST_HALT);

endmodule
`default_nettype wire

/* dv/host_model.sv */
// host controller model: strobe writes and reads on the register port
// assumes the bank samples strobes on rising clk
`timescale 1ns/1ps
`default_nettype none
module host_model
    import led_cfg_pkg::*;
(
    // clock
    input wire logic              clk,
    // register port
    output var logic              reg_wr,
    output var logic              reg_rd,
    output var logic [ADDR_W-1:0] reg_addr,
    output var logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        d = 'x;
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                break;
            end
        end
    endtask
    // each byte takes effect alone, so the code passes through a mix
    task automatic set_period(input logic [PERIOD_W-1:0] code);
        write(ADDR_PERIOD_UPPER, {3'h0, code[12:8]});
        write(ADDR_PERIOD_LOWER, code[7:0]);
    endtask
endmodule
`default_nettype wire

/* dv/led_cfg_checker.sv */
// checker for the led driver configuration bank
// assumes one clock domain, bound onto led_cfg_regs
`timescale 1ns/1ps
`default_nettype none
module led_cfg_checker
    import led_cfg_pkg::*;
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset_n,
    // register port
    input wire logic                 reg_wr,
    input wire logic [ADDR_W-1:0]    reg_addr,
    input wire logic [DATA_W-1:0]    reg_wdata,
    // pins and startup
    input wire logic [NUM_CH-1:0]    unpopulated_pin,
    input wire logic                 freq_set_or_ext_sync_pin,
    input wire logic                 start_req,
    input wire logic                 startup_running,
    input wire logic                 startup_halted,
    input wire logic                 fault_flag_n,
    // outputs
    input wire logic [NUM_CH-1:0]    chan_drive,
    input wire logic                 period_start,
    input wire logic                 full_duty_lost,
    input wire logic [OV_CODE_W-1:0] overvoltage_trip_code,
    input wire logic [5:0]           ov_trip_volts,
    input wire logic                 thermal_derate_on,
    input wire dither_t              dither_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    // shadow of the period code and cycles between period pulses
    logic [PERIOD_W-1:0] per_q;
    logic [1:0]          dirty_q;
    logic [17:0]         gap_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            per_q <= 13'h0fff;
        end else if (reg_wr && reg_addr == ADDR_PERIOD_UPPER) begin
            per_q[12:8] <= reg_wdata[4:0];
        end else if (reg_wr && reg_addr == ADDR_PERIOD_LOWER) begin
            per_q[7:0] <= reg_wdata;
        end
    end
    // two period pulses must pass after a change before lengths count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dirty_q <= 2'h2;
        end else if (!startup_running || (reg_wr && reg_addr inside {ADDR_PERIOD_UPPER, ADDR_PERIOD_LOWER})) begin
            dirty_q <= 2'h2;
        end else if (period_start && dirty_q != 2'h0) begin
            dirty_q <= dirty_q - 2'h1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= 18'h0;
        end else begin
            gap_q <= period_start ? 18'h0 : gap_q + 18'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_period_length: assert property (period_start && dirty_q == 2'h0 |->
        int'(gap_q) == (int'(per_q) + 1) * STEP_CYCLES - 1) else $error("dimming period length wrong");
    a_duty_lost_flag: assert property ($stable(per_q)[*3] |->
        full_duty_lost == (per_q > 13'd6552)) else $error("full duty flag wrong");
    a_trip_code_write: assert property (reg_wr && reg_addr == ADDR_OV_TRIP |=>
        overvoltage_trip_code == $past(reg_wdata[4:0])) else $error("trip code not written");
    a_trip_volts_sum: assert property ($past(reset_n) |->
        ov_trip_volts == OV_BASE_VOLTS + 6'($past(overvoltage_trip_code))) else $error("trip volts wrong");
    a_derate_bit_copy: assert property (reg_wr && reg_addr == ADDR_DITHER_DERATE |->
        ##2 thermal_derate_on == $past(reg_wdata[BIT_DERATE], 2)) else $error("derate enable wrong");
    a_sync_no_dither: assert property (freq_set_or_ext_sync_pin[*4] |->
        dither_sel == DITHER_NONE) else $error("dither active under external sync");
    a_unpop_stays_dark: assert property ($stable(unpopulated_pin)[*8] |->
        (chan_drive & unpopulated_pin) == '0) else $error("unpopulated channel lit");
    // flag lags the combination by one cycle, so both are compared after the decision
    a_bad_start_halts: assert property (start_req && !startup_running |=>
        startup_halted == !fault_flag_n && startup_running == fault_flag_n) else $error("startup decision wrong");
endmodule
bind led_cfg_regs led_cfg_checker led_cfg_checker_i (.clk, .reset_n, .reg_wr, .reg_addr, .reg_wdata,
    .unpopulated_pin, .freq_set_or_ext_sync_pin, .start_req, .startup_running, .startup_halted,
    .fault_flag_n, .chan_drive, .period_start, .full_duty_lost, .overvoltage_trip_code,
    .ov_trip_volts, .thermal_derate_on, .dither_sel);
`default_nettype wire

/* dv/led_cfg_regs_tb_top.sv */
// self-checking bench for the led driver configuration bank
// assumes host_model drives the register port
`timescale 1ns/1ps
`default_nettype none
module led_cfg_regs_tb_top;
    import led_cfg_pkg::*;
    logic clk = 1'b0, reset_n, start_req, freq_set_or_ext_sync_pin, reg_wr, reg_rd, reg_rvalid;
    logic startup_running, startup_halted, fault_flag_n, period_start, full_duty_lost, thermal_derate_on;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic [NUM_CH-1:0] unpopulated_pin, chan_drive, en;
    logic [PERIOD_W-1:0] on_steps;
    logic [OV_CODE_W-1:0] overvoltage_trip_code;
    logic [5:0] ov_trip_volts;
    dither_t dither_sel;
    int seed, errors, n_checks, cycles, r;
    always #12.5 clk = ~clk;
    host_model host_model_i (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
    led_cfg_regs led_cfg_regs_i (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .unpopulated_pin, .freq_set_or_ext_sync_pin, .start_req, .startup_running,
        .startup_halted, .fault_flag_n, .on_steps, .chan_drive, .period_start, .full_duty_lost,
        .overvoltage_trip_code, .ov_trip_volts, .thermal_derate_on, .dither_sel);
    ////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] rst_of(input int a);
        case (a)
            0: rst_of = 8'h03;
            1, 3: rst_of = 8'hff;
            2: rst_of = 8'h0f;
            4: rst_of = 8'h1c;
            default: rst_of = 8'h00;
        endcase
    endfunction
    function automatic logic [DATA_W-1:0] mask_of(input int a);
        case (a)
            0: mask_of = 8'h03;
            1, 3: mask_of = 8'hff;
            2, 4: mask_of = 8'h1f;
            5: mask_of = 8'h07;
            default: mask_of = 8'h00;
        endcase
    endfunction
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_chan(input logic [NUM_CH-1:0] exp);
        n_checks++;
        if (chan_drive !== exp) begin
            errors++;
            $display("[FAIL] chan_drive expected %h seen %h", exp, chan_drive);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_period();
        for (int i = 0; i < 20000; i++) begin
            @(posedge clk);
            if (period_start === 1'b1) break;
        end
    endtask
    task automatic put_en(input logic [NUM_CH-1:0] v);
        host_model_i.write(ADDR_CHAN_ON_UPPER, {6'h0, v[9:8]});
        host_model_i.write(ADDR_CHAN_ON_LOWER, v[7:0]);
    endtask
    task automatic pulse_start();
        start_req <= 1'b1;
        settle(1);
        start_req <= 1'b0;
        settle(2);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 53550;
        reset_n = 1'b0;
        start_req = 1'b0;
        freq_set_or_ext_sync_pin = 1'b0;
        unpopulated_pin = '0;
        on_steps = 13'h1fff;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            host_model_i.read(8'(a), d);
            check_byte("reset value", rst_of(a), d);
            host_model_i.write(8'(a), 8'hff);
            host_model_i.read(8'(a), d);
            check_byte("masked readback", mask_of(a), d);
        end
        settle(3);
        check_byte("duty lost", 8'h01, {7'h0, full_duty_lost});
        host_model_i.set_period(13'd6552);
        settle(3);
        check_byte("duty lost", 8'h00, {7'h0, full_duty_lost});
        for (int a = 0; a < 4; a++) begin
            r = $random(seed);
            host_model_i.write(ADDR_DITHER_DERATE, {5'h0, r[0], 2'(a)});
            settle(3);
            check_byte("dither", 8'(a), {6'h0, dither_sel});
            check_byte("derate", {7'h0, r[0]}, {7'h0, thermal_derate_on});
            freq_set_or_ext_sync_pin <= 1'b1;
            settle(5);
            check_byte("dither sync", 8'h00, {6'h0, dither_sel});
            freq_set_or_ext_sync_pin <= 1'b0;
        end
        r = $random(seed);
        host_model_i.write(ADDR_OV_TRIP, r[7:0]);
        settle(3);
        check_byte("trip code", {3'h0, r[4:0]}, {3'h0, overvoltage_trip_code});
        check_byte("trip volts", 8'd8 + {3'h0, r[4:0]}, {2'h0, ov_trip_volts});
        host_model_i.set_period(13'd30);
        unpopulated_pin <= 10'h001 << ($unsigned($random(seed)) % NUM_CH);
        settle(6);
        check_byte("fault flag", 8'h00, {7'h0, fault_flag_n});
        pulse_start();
        check_byte("halted", 8'h01, {7'h0, startup_halted});
        check_byte("running", 8'h00, {7'h0, startup_running});
        put_en(~unpopulated_pin);
        settle(4);
        check_byte("fault flag", 8'h01, {7'h0, fault_flag_n});
        pulse_start();
        check_byte("running", 8'h01, {7'h0, startup_running});
        // enabling the unpopulated channel would halt the run, so it stays off here
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            en = ((i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : r[9:0]) & ~unpopulated_pin;
            put_en(en);
            host_model_i.set_period(13'd29 + 13'($unsigned($random(seed)) % 62));
            repeat (3) wait_period();
            settle(30);
            check_chan(en & ~unpopulated_pin);
        end
        // short on-time: lit in step 0, dark from step 3 on
        on_steps <= 13'h0002;
        wait_period();
        settle(30);
        check_chan(en);
        settle(270);
        check_chan('0);
        complete_run();
    end
endmodule
`default_nettype wire
